// ---- design/i2c_master_arb.sv ----
// two-wire master sequencer with arbitration and axi4-lite registers
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module i2c_master_arb (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        sleep_mode,
	input  wire logic        slave_event,
	output logic             irq_out,
	output logic             wake_out
);
	function automatic logic [2:0] reg_idx(input logic [3:0] a);
		unique case (a)
			i2c_arb_pkg::CTRL_OFS:   reg_idx = 3'h1;
			i2c_arb_pkg::STAT_OFS:   reg_idx = 3'h2;
			i2c_arb_pkg::BUF_OFS:    reg_idx = 3'h3;
			i2c_arb_pkg::RELOAD_OFS: reg_idx = 3'h4;
			default:                 reg_idx = 3'h0;
		endcase
	endfunction : reg_idx

	i2c_arb_pkg::ctrl_s  ctrl_q;
	i2c_arb_pkg::state_e state_q;
	logic [7:0]  reload_q, buf_q, cnt_q;
	logic [3:0]  bit_q;
	logic [1:0]  scl_s_q, sda_s_q;
	logic        scl_p_q, sda_p_q;
	logic        start_det_q, stop_det_q, bf_q, mif_q, bcl_q, write_collision_flag_q;
	logic        ev_bcl_q, ev_bfc_q, ev_mif_q, ev_done_q;
	logic        aw_v_q, w_v_q;
	logic [3:0]  awaddr_q;
	logic [7:0]  wdata_q;
	logic        wstrb_q;
	logic        scl, sda, tmo, wr_fire, wr_buf, wr_ctrl, wr_stat;
	logic        mon_stop, mon_start, in_stop;

	assign scl = scl_s_q[1];
	assign sda = sda_s_q[1];
	assign tmo = (cnt_q == 8'h00);
	assign wr_fire = aw_v_q && w_v_q && !bvalid;
	assign wr_buf = wr_fire && wstrb_q &&
		(reg_idx(awaddr_q) == 3'h3);
	assign wr_ctrl = wr_fire && wstrb_q &&
		(reg_idx(awaddr_q) == 3'h1);
	assign wr_stat = wr_fire && wstrb_q &&
		(reg_idx(awaddr_q) == 3'h2);
	assign mon_stop = scl && scl_p_q && sda && !sda_p_q;
	assign mon_start = scl && scl_p_q && !sda && sda_p_q;
	assign in_stop = (state_q == i2c_arb_pkg::S_SP_D) ||
		(state_q == i2c_arb_pkg::S_SP_E);

	// pin synchronisers and edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	// axi4-lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= i2c_arb_pkg::RESP_OKAY;
			aw_v_q <= 1'b0;
			w_v_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				aw_v_q <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wdata_q <= wdata[7:0];
				wstrb_q <= wstrb[0];
				w_v_q <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				aw_v_q <= 1'b0;
				w_v_q <= 1'b0;
				bresp <= (reg_idx(awaddr_q) == 3'h0) ?
					i2c_arb_pkg::RESP_ERR : i2c_arb_pkg::RESP_OKAY;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// axi4-lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= i2c_arb_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= i2c_arb_pkg::RESP_OKAY;
			unique case (reg_idx(araddr))
				3'h1: rdata <= {24'h00_0000, ctrl_q};
				3'h2: rdata <= {26'h000_0000, write_collision_flag_q, bcl_q, mif_q,
					bf_q, start_det_q, stop_det_q};
				3'h3: rdata <= {24'h00_0000, buf_q};
				3'h4: rdata <= {24'h00_0000, reload_q};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= i2c_arb_pkg::RESP_ERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// control and reload registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= i2c_arb_pkg::CTRL_RST;
			reload_q <= i2c_arb_pkg::RELOAD_RST;
		end else begin
			if (ev_done_q) begin
				ctrl_q.start_enable <= 1'b0;
				ctrl_q.repeat_start_enable <= 1'b0;
				ctrl_q.stop_enable <= 1'b0;
				ctrl_q.ack_sequence_enable <= 1'b0;
			end
			if (wr_ctrl)
				ctrl_q <= i2c_arb_pkg::ctrl_s'(wdata_q);
			if (wr_fire && wstrb_q && reg_idx(awaddr_q) == 3'h4)
				reload_q <= wdata_q;
		end
	end

	// buffer, write collision and sticky flags; hardware set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_q <= 8'h00;
			bf_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			bcl_q <= 1'b0;
			mif_q <= 1'b0;
		end else begin
			if (wr_buf && state_q == i2c_arb_pkg::S_IDLE) begin
				buf_q <= wdata_q;
				bf_q <= 1'b1;
			end else if (ev_bfc_q)
				bf_q <= 1'b0;
			if (wr_stat && wdata_q[5])
				write_collision_flag_q <= 1'b0;
			if (wr_buf && state_q != i2c_arb_pkg::S_IDLE)
				write_collision_flag_q <= 1'b1;
			if (wr_stat && wdata_q[4])
				bcl_q <= 1'b0;
			if (ev_bcl_q)
				bcl_q <= 1'b1;
			if (wr_stat && wdata_q[3])
				mif_q <= 1'b0;
			if (ev_mif_q || (mon_stop && !in_stop &&
				(start_det_q || bcl_q)))
				mif_q <= 1'b1;
		end
	end

	// bus monitor: start and stop seen
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_q.enable) begin
			start_det_q <= 1'b0;
			stop_det_q <= 1'b0;
		end else if (mon_stop) begin
			stop_det_q <= 1'b1;
			start_det_q <= 1'b0;
		end else if (mon_start) begin
			start_det_q <= 1'b1;
			stop_det_q <= 1'b0;
		end
	end

	// interrupt and wake outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_out <= 1'b0;
			wake_out <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			irq_out <= mif_q && ctrl_q.irq_en;
			wake_out <= sleep_mode && slave_event &&
				ctrl_q.irq_en;
		end
	end

	// condition sequencer with baud counter
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_q.enable) begin
			state_q <= i2c_arb_pkg::S_IDLE;
			cnt_q <= 8'h00;
			bit_q <= i2c_arb_pkg::BIT_FIRST;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			ev_bcl_q <= 1'b0;
			ev_bfc_q <= 1'b0;
			ev_mif_q <= 1'b0;
			ev_done_q <= 1'b0;
		end else begin
			ev_bcl_q <= 1'b0;
			ev_bfc_q <= 1'b0;
			ev_mif_q <= 1'b0;
			ev_done_q <= 1'b0;
			if (!tmo)
				cnt_q <= cnt_q - 8'h01;
			unique case (state_q)
				i2c_arb_pkg::S_IDLE: begin
					if (ev_done_q || ev_bcl_q) begin
					end else if (ctrl_q.start_enable) begin
						scl_oe <= 1'b0;
						sda_oe <= 1'b0;
						state_q <= i2c_arb_pkg::S_ST_CHK;
					end else if (ctrl_q.repeat_start_enable) begin
						sda_oe <= 1'b0;
						state_q <= i2c_arb_pkg::S_RS_A;
					end else if (ctrl_q.stop_enable) begin
						sda_oe <= 1'b1;
						state_q <= i2c_arb_pkg::S_SP_A;
					end else if (ctrl_q.ack_sequence_enable) begin
						scl_oe <= 1'b1;
						sda_oe <= !ctrl_q.ack_data_value;
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_AK_LO;
					end else if (bf_q) begin
						bit_q <= i2c_arb_pkg::BIT_FIRST;
						scl_oe <= 1'b1;
						sda_oe <= !buf_q[7];
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_TX_LO;
					end
				end
				i2c_arb_pkg::S_ST_CHK: begin
					if (!sda || !scl) begin
						ev_bcl_q <= 1'b1;
						ev_done_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else begin
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_ST_A;
					end
				end
				i2c_arb_pkg::S_ST_A: begin
					if (!scl && sda) begin
						ev_bcl_q <= 1'b1;
						ev_done_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else if (!sda || tmo) begin
						sda_oe <= 1'b1;
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_ST_B;
					end
				end
				i2c_arb_pkg::S_ST_B: if (tmo) begin
					scl_oe <= 1'b1;
					ev_done_q <= 1'b1;
					ev_mif_q <= 1'b1;
					state_q <= i2c_arb_pkg::S_IDLE;
				end
				i2c_arb_pkg::S_RS_A: if (sda) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_RS_B;
				end
				i2c_arb_pkg::S_RS_B: if (tmo) begin
					scl_oe <= 1'b0;
					state_q <= i2c_arb_pkg::S_RS_C;
				end
				i2c_arb_pkg::S_RS_C: if (scl) begin
					if (!sda) begin
						sda_oe <= 1'b0;
						ev_bcl_q <= 1'b1;
						ev_done_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else begin
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_RS_D;
					end
				end
				i2c_arb_pkg::S_RS_D: begin
					if (!scl && sda) begin
						ev_bcl_q <= 1'b1;
						ev_done_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else if (tmo || !sda) begin
						sda_oe <= 1'b1;
						cnt_q <= reload_q;
						state_q <= i2c_arb_pkg::S_RS_E;
					end
				end
				i2c_arb_pkg::S_RS_E: if (tmo) begin
					scl_oe <= 1'b1;
					ev_done_q <= 1'b1;
					ev_mif_q <= 1'b1;
					state_q <= i2c_arb_pkg::S_IDLE;
				end
				i2c_arb_pkg::S_TX_LO: if (tmo) begin
					scl_oe <= 1'b0;
					state_q <= i2c_arb_pkg::S_TX_W;
				end
				i2c_arb_pkg::S_TX_W: if (scl) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_TX_HI;
				end
				i2c_arb_pkg::S_TX_HI: begin
					if (!sda_oe && !sda && bit_q != 4'h0) begin
						scl_oe <= 1'b0;
						ev_bcl_q <= 1'b1;
						ev_bfc_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else if (tmo) begin
						scl_oe <= 1'b1;
						cnt_q <= reload_q;
						bit_q <= bit_q - 4'h1;
						if (bit_q == 4'h0) begin
							ev_mif_q <= 1'b1;
							state_q <= i2c_arb_pkg::S_IDLE;
						end else begin
							if (bit_q == 4'h1)
								ev_bfc_q <= 1'b1;
							sda_oe <= (bit_q == 4'h1) ? 1'b0 :
								!buf_q[3'(bit_q - 4'h2)];
							state_q <= i2c_arb_pkg::S_TX_LO;
						end
					end
				end
				i2c_arb_pkg::S_AK_LO: if (tmo) begin
					scl_oe <= 1'b0;
					state_q <= i2c_arb_pkg::S_AK_W;
				end
				i2c_arb_pkg::S_AK_W: if (scl) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_AK_HI;
				end
				i2c_arb_pkg::S_AK_HI: begin
					if (!sda_oe && !sda) begin
						ev_bcl_q <= 1'b1;
						ev_done_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end else if (tmo) begin
						scl_oe <= 1'b1;
						ev_done_q <= 1'b1;
						ev_mif_q <= 1'b1;
						state_q <= i2c_arb_pkg::S_IDLE;
					end
				end
				i2c_arb_pkg::S_SP_A: if (!sda) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_SP_B;
				end
				i2c_arb_pkg::S_SP_B: if (tmo) begin
					scl_oe <= 1'b0;
					state_q <= i2c_arb_pkg::S_SP_W;
				end
				i2c_arb_pkg::S_SP_W: if (scl) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_SP_C;
				end
				i2c_arb_pkg::S_SP_C: if (tmo) begin
					sda_oe <= 1'b0;
					state_q <= i2c_arb_pkg::S_SP_D;
				end
				i2c_arb_pkg::S_SP_D: if (sda && scl) begin
					cnt_q <= reload_q;
					state_q <= i2c_arb_pkg::S_SP_E;
				end
				i2c_arb_pkg::S_SP_E: if (tmo) begin
					ev_done_q <= 1'b1;
					ev_mif_q <= 1'b1;
					state_q <= i2c_arb_pkg::S_IDLE;
				end
				default: state_q <= i2c_arb_pkg::S_IDLE;
			endcase
			if (ev_bcl_q) begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ack_drive;
		state_q == i2c_arb_pkg::S_AK_LO |->
			scl_oe && (sda_oe == !ctrl_q.ack_data_value);
	endproperty
	a_ack_drive: assert property (p_ack_drive)
		else $error("ack drive wrong");
	property p_ack_rel;
		state_q == i2c_arb_pkg::S_AK_W |-> !scl_oe;
	endproperty
	a_ack_rel: assert property (p_ack_rel)
		else $error("ack clock not released");
	property p_ack_end;
		state_q == i2c_arb_pkg::S_AK_HI && tmo && sda_oe |=>
			state_q == i2c_arb_pkg::S_IDLE ##1
			!ctrl_q.ack_sequence_enable || wr_ctrl;
	endproperty
	a_ack_end: assert property (p_ack_end)
		else $error("ack enable not cleared");
	property p_write_collision_flag;
		wr_buf && state_q != i2c_arb_pkg::S_IDLE |=>
			$stable(buf_q) && write_collision_flag_q;
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("busy write not dropped");
	property p_start_abort;
		state_q == i2c_arb_pkg::S_ST_CHK && (!sda || !scl) |=>
			state_q == i2c_arb_pkg::S_IDLE ##1 bcl_q;
	endproperty
	a_start_abort: assert property (p_start_abort)
		else $error("start abort missing");
	property p_bcl_rel;
		ev_bcl_q && ctrl_q.enable |=> !scl_oe && !sda_oe;
	endproperty
	a_bcl_rel: assert property (p_bcl_rel)
		else $error("lines held after collision");
	property p_disable;
		!ctrl_q.enable |=> !start_det_q && !stop_det_q &&
			state_q == i2c_arb_pkg::S_IDLE;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disable did not clear");
	property p_rs_end;
		state_q == i2c_arb_pkg::S_RS_E && tmo && ctrl_q.enable
			|=> scl_oe && sda_oe;
	endproperty
	a_rs_end: assert property (p_rs_end)
		else $error("repeat start end wrong");
endmodule : i2c_master_arb

// ---- include/i2c_arb_pkg.sv ----
// constants, types and layout for the two-wire master arbitration block
// Operation
// - ack enable pulls clock low, data line shows ack data value
// - ack: one period, release clock, wait high, one period, clock low
// - ack end clears ack enable, stops counter, returns to idle
// - buffer write during ack or stop is dropped, write collision set
// - stop: data low, once low count, release clock, then data later
// - data high with clock high sets stop seen, then irq flag
// - in sleep, slave events wake the cpu if interrupt enabled
// - reset or disable aborts transfer and clears start/stop seen
// - busy bus with interrupt enabled: stop on bus raises interrupt
// - released one read back as zero is a collision, go idle
// - transmit collision: halt, clear full flag, release both lines
// - condition collision: abort, release lines, clear its enable bit
// - after collision keep watching; a bus stop sets irq flag
// - buffer write after collision restarts from first data bit
// - start with a line already low: abort, collision, idle
// - start: load counter on data high; clock low then collides
// - data low in first start count: restart count, drive early
// - start: data low at count end, recount, then clock low
// - repeat start: release data, count, release clock, check data
// - repeat start: clock fall before timeout without data low collides
// - repeat start: both high at end, data low, recount, clock low
package i2c_arb_pkg;
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STAT_OFS   = 4'h4;
	localparam logic [3:0] BUF_OFS    = 4'h8;
	localparam logic [3:0] RELOAD_OFS = 4'hC;
	localparam logic [7:0] RELOAD_RST = 8'h09;
	localparam logic [3:0] BIT_FIRST  = 4'h8;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_ERR   = 2'h2;

	// control register, bit 7 down to bit 0
	typedef struct packed {
		logic irq_en;
		logic ack_data_value;
		logic ack_sequence_enable;
		logic spare;
		logic stop_enable;
		logic repeat_start_enable;
		logic start_enable;
		logic enable;
	} ctrl_s;
	localparam ctrl_s CTRL_RST = '0;

	typedef enum logic [4:0] {
		S_IDLE, S_ST_CHK, S_ST_A, S_ST_B,
		S_RS_A, S_RS_B, S_RS_C, S_RS_D, S_RS_E,
		S_TX_LO, S_TX_W, S_TX_HI,
		S_AK_LO, S_AK_W, S_AK_HI,
		S_SP_A, S_SP_B, S_SP_W, S_SP_C, S_SP_D, S_SP_E
	} state_e;
endpackage : i2c_arb_pkg

// ---- tb/i2c_bus_model.sv ----
// open-drain two-wire bus with pull-ups and a second bus party
module i2c_bus_model (
	input  wire logic aclk,
	input  wire logic sda_oe,
	input  wire logic scl_oe,
	output logic      sda,
	output logic      scl
);
	timeunit 1ns;
	timeprecision 1ns;

	logic pull_sda = 1'b0;
	logic pull_scl = 1'b0;

	// released lines float high through the pull-ups
	assign sda = !(sda_oe || pull_sda);
	assign scl = !(scl_oe || pull_scl);

	// other master: start then stop, four clock cycles apart
	task automatic bus_stop();
		@(posedge aclk);
		pull_sda <= 1'b1;
		repeat (4) @(posedge aclk);
		pull_sda <= 1'b0;
	endtask : bus_stop
endmodule : i2c_bus_model

// ---- tb/i2c_master_ack_stop_arbitration_test.sv ----
// self-checking bench for the two-wire master arbitration block
module i2c_master_ack_stop_arbitration_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [3:0] CT = i2c_arb_pkg::CTRL_OFS;
	localparam logic [3:0] ST = i2c_arb_pkg::STAT_OFS;
	localparam logic [3:0] BU = i2c_arb_pkg::BUF_OFS;
	localparam logic [3:0] RL = i2c_arb_pkg::RELOAD_OFS;

	typedef struct packed {
		logic        wr;
		logic [3:0]  a;
		logic [31:0] d;
		logic [1:0]  r;
	} row_s;

	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rdv;
	logic [1:0]  bresp, rresp, rsp;
	logic        sda, scl, sda_out, sda_oe, scl_out, scl_oe;
	logic        sleep_mode, slave_event, irq_out, wake_out, seen;
	logic        sda_q = 1'b1;
	logic        scl_q = 1'b1;
	logic [8:0]  sh = '0;
	int          fails, comparisons, nsp;
	row_s        rows [9];

	i2c_master_arb u_i2c_master_arb (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .scl_in(scl), .scl_out,
		.scl_oe, .sda_in(sda), .sda_out, .sda_oe, .sleep_mode, .slave_event,
		.irq_out, .wake_out
	);

	i2c_bus_model u_i2c_bus_model (
		.aclk, .sda_oe, .scl_oe, .sda, .scl
	);

	// wire monitor: bits on clock rise, stops on data rise
	always @(posedge aclk) begin
		sda_q <= sda;
		scl_q <= scl;
		if (scl && !scl_q)
			sh <= {sh[7:0], sda};
		if (scl && scl_q && !sda_q && sda)
			nsp++;
	end

	task automatic stop_test();
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				rsp = bresp;
				bready <= 1'b0;
				return;
			end
		end
		fails++;
		stop_test();
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rdv = rdata;
				rsp = rresp;
				rready <= 1'b0;
				return;
			end
		end
		fails++;
		stop_test();
	endtask : rd

	task automatic rdc(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a);
		check(rdv & m, e);
	endtask : rdc

	// wait until all status bits in m are set
	task automatic poll(input logic [31:0] m);
		for (int n = 0; n < 200; n++) begin
			rd(ST);
			if ((rdv & m) === m)
				return;
		end
		fails++;
		stop_test();
	endtask : poll

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		sleep_mode = 1'b0;
		slave_event = 1'b0;
		rows = '{
			'{1'b0, RL, 32'h09, 2'h0}, '{1'b0, CT, 32'h00, 2'h0},
			'{1'b0, ST, 32'h00, 2'h0}, '{1'b1, RL, 32'h03, 2'h0},
			'{1'b0, RL, 32'h03, 2'h0}, '{1'b1, 4'h6, 32'h01, 2'h2},
			'{1'b0, 4'h6, 32'h00, 2'h2}, '{1'b1, CT, 32'h81, 2'h0},
			'{1'b0, CT, 32'h81, 2'h0}};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		check({30'h0, sda_oe, scl_oe}, 32'h0);
		check({30'h0, sda_out, scl_out}, 32'h0);
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				rdc(rows[i].a, 32'hffff_ffff, rows[i].d);
			check({30'h0, rsp}, {30'h0, rows[i].r});
		end
		// start, byte, repeated start
		rdc(ST, 32'h03, 32'h0);
		wr(CT, 32'h83);
		poll(32'h08);
		check({30'h0, sda_oe, scl_oe}, 32'h3);
		wr(ST, 32'h38);
		wr(BU, 32'ha5);
		poll(32'h08);
		check({23'h0, sh}, 32'h14b);
		rdc(ST, 32'h3c, 32'h08);
		wr(ST, 32'h38);
		wr(CT, 32'h85);
		poll(32'h08);
		rdc(CT, 32'hff, 32'h81);
		check({30'h0, sda_oe, scl_oe}, 32'h3);
		// acknowledge and not-acknowledge, stretched, with dropped write
		for (int i = 0; i < 2; i++) begin
			wr(ST, 32'h38);
			wr(CT, {24'h0, 1'b1, i[0], 6'h21});
			u_i2c_bus_model.pull_scl <= 1'b1;
			wr(BU, 32'h3c);
			repeat (8) @(posedge aclk);
			u_i2c_bus_model.pull_scl <= 1'b0;
			poll(32'h08);
			check({31'h0, sh[0]}, {31'h0, i[0]});
			rdc(ST, 32'h3c, 32'h28);
			rdc(CT, 32'hff, {24'h0, 1'b1, i[0], 6'h01});
			check({31'h0, scl_oe}, 32'h1);
		end
		// stop with dropped write
		wr(ST, 32'h38);
		wr(CT, 32'h89);
		wr(BU, 32'h55);
		poll(32'h08);
		rdc(ST, 32'h3d, 32'h29);
		rdc(CT, 32'hff, 32'h81);
		check({30'h0, sda_oe, scl_oe}, 32'h0);
		check(nsp, 32'h1);
		// lost arbitration on a one
		wr(ST, 32'h38);
		wr(CT, 32'h83);
		poll(32'h08);
		wr(ST, 32'h38);
		wr(BU, 32'hff);
		u_i2c_bus_model.pull_sda <= 1'b1;
		poll(32'h10);
		u_i2c_bus_model.pull_sda <= 1'b0;
		rdc(ST, 32'h14, 32'h10);
		check({30'h0, sda_oe, scl_oe}, 32'h0);
		wr(ST, 32'h38);
		u_i2c_bus_model.bus_stop();
		poll(32'h08);
		check({31'h0, irq_out}, 32'h1);
		// resend from the first bit
		wr(ST, 32'h38);
		wr(CT, 32'h83);
		poll(32'h08);
		wr(ST, 32'h38);
		wr(BU, 32'h81);
		poll(32'h08);
		check({23'h0, sh}, 32'h103);
		wr(ST, 32'h38);
		wr(CT, 32'h89);
		poll(32'h08);
		// another party pulls clock, then data, low in the start count
		for (int i = 0; i < 2; i++) begin
			wr(ST, 32'h38);
			wr(CT, 32'h83);
			@(posedge aclk);
			if (i == 0)
				u_i2c_bus_model.pull_scl <= 1'b1;
			else
				u_i2c_bus_model.pull_sda <= 1'b1;
			poll({27'h0, !i[0], i[0], 3'h0});
			u_i2c_bus_model.pull_scl <= 1'b0;
			u_i2c_bus_model.pull_sda <= 1'b0;
			rdc(ST, 32'h10, {27'h0, !i[0], 4'h0});
			rdc(CT, 32'hff, 32'h81);
			check({30'h0, sda_oe, scl_oe}, {30'h0, i[0], i[0]});
		end
		wr(ST, 32'h38);
		wr(CT, 32'h89);
		poll(32'h08);
		// start with data already low
		u_i2c_bus_model.pull_sda <= 1'b1;
		wr(CT, 32'h83);
		poll(32'h10);
		rdc(CT, 32'hff, 32'h81);
		check({30'h0, sda_oe, scl_oe}, 32'h0);
		u_i2c_bus_model.pull_sda <= 1'b0;
		// wake from sleep only with interrupt enabled
		for (int i = 0; i < 2; i++) begin
			wr(CT, {24'h0, i[0], 7'h01});
			sleep_mode <= 1'b1;
			@(posedge aclk);
			slave_event <= 1'b1;
			@(posedge aclk);
			slave_event <= 1'b0;
			seen = 1'b0;
			repeat (3) begin
				@(posedge aclk);
				seen = seen | wake_out;
			end
			check({31'h0, seen}, {31'h0, i[0]});
		end
		sleep_mode <= 1'b0;
		// disable, then reset in mid-start
		wr(ST, 32'h38);
		wr(CT, 32'h83);
		poll(32'h02);
		wr(CT, 32'h00);
		rdc(ST, 32'h03, 32'h0);
		wr(CT, 32'h83);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		check({30'h0, sda_oe, scl_oe}, 32'h0);
		rdc(ST, 32'hff, 32'h0);
		rdc(CT, 32'hff, 32'h0);
		stop_test();
	end
endmodule : i2c_master_ack_stop_arbitration_test
